// ===== rtl/ind_conv_pkg.sv
// constants and carrier types for the inductance result and high-resolution setup block
package ind_conv_pkg;

	// ********************************
	// register map
	// ********************************
	localparam logic [6:0] ADDR_LOSS_LOW = 7'h21;
	localparam logic [6:0] ADDR_IND_LOW = 7'h23;
	localparam logic [6:0] ADDR_IND_HIGH = 7'h24;
	localparam logic [6:0] ADDR_REF_COUNT_LOW = 7'h30;
	localparam logic [6:0] ADDR_REF_COUNT_HIGH = 7'h31;
	localparam logic [6:0] ADDR_OFFSET_LOW = 7'h32;
	localparam logic [6:0] ADDR_OFFSET_HIGH = 7'h33;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ********************************
	// field positions and timing
	// ********************************
	localparam int CMD_READ_BIT = 7;
	localparam int BYTE_LAST_BIT = 7;
	localparam int CLK_PERIOD_NS = 8;
	localparam int HIRES_COUNT_MULT = 16;
	localparam int HIRES_COUNT_EXTRA = 55;
	localparam int IND_DIVISOR = 3;
	localparam int HIRES_OFFSET_SHIFT = 8;

	// ********************************
	// types
	// ********************************
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_ADDR = 2'b01,
		SPI_DATA = 2'b10,
		SPI_DONE = 2'b11
	} spi_state_e;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
	} spi_in_s;

	typedef struct packed {
		logic sdo;
		logic sdo_oe;
	} spi_out_s;

endpackage

// ===== rtl/inductance_result_hires_ctrl.sv
// serial register port, inductance result capture and high-resolution conversion timing
`timescale 1ns/1ps
module inductance_result_hires_ctrl #(
	parameter int RESULT_W = 16,
	parameter int HIRES_W = 24
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire ind_conv_pkg::spi_in_s spi_in,
	output ind_conv_pkg::spi_out_s spi_out,
	input wire logic sensor_edge,
	input wire logic [15:0] response_time_setting,
	input wire logic [HIRES_W-1:0] hires_raw,
	output logic hires_conv_done,
	output logic [HIRES_W-1:0] hires_result,
	output logic [15:0] hires_reference_count,
	output logic [15:0] hires_offset
);
	import ind_conv_pkg::*;

	// ********************************
	// serial port
	// ********************************
	spi_state_e state_reg;
	logic sclk_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic rd_reg;
	logic [6:0] addr_reg;
	logic sclk_rise;
	logic byte_done;
	logic [7:0] shift_next;
	logic [7:0] rdata;
	logic wr_strobe;

	// registers
	logic [7:0] ref_count_lo_reg;
	logic [7:0] ref_count_hi_reg;
	logic [7:0] offset_lo_reg;
	logic [7:0] offset_hi_reg;
	logic [RESULT_W-1:0] ind_live_reg;
	logic [RESULT_W-1:0] ind_hold_reg;

	// measurement
	logic [15:0] sens_cnt_reg;
	logic [1:0] div3_reg;
	logic [RESULT_W-1:0] acc_reg;
	logic window_end;
	logic [20:0] conv_cnt_reg;
	logic [20:0] conv_len;

	// pins are synchronous to clk, so a single delay gives the edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_reg <= 1'b0;
		end else begin
			sclk_reg <= spi_in.sclk;
		end
	end

	assign sclk_rise = spi_in.sclk & ~sclk_reg & ~spi_in.cs_n;
	assign byte_done = sclk_rise && (bit_cnt_reg == 3'(BYTE_LAST_BIT));
	assign shift_next = {shift_reg[6:0], spi_in.sdi};
	assign wr_strobe = byte_done && (state_reg == SPI_DATA) && !rd_reg;

	// frame sequencing: one command byte, one data byte, rest ignored until deselect
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= SPI_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			rd_reg <= 1'b0;
			addr_reg <= 7'h00;
		end else if (spi_in.cs_n) begin
			state_reg <= SPI_IDLE;
			bit_cnt_reg <= 3'h0;
		end else begin
			if (sclk_rise) begin
				shift_reg <= shift_next;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
			end
			case (state_reg)
				SPI_IDLE: begin
					state_reg <= SPI_ADDR;
				end
				SPI_ADDR: begin
					if (byte_done) begin
						rd_reg <= shift_next[CMD_READ_BIT];
						addr_reg <= shift_next[6:0];
						state_reg <= SPI_DATA;
					end
				end
				SPI_DATA: begin
					if (byte_done) begin
						state_reg <= SPI_DONE;
					end
				end
				SPI_DONE: begin
					state_reg <= SPI_DONE;
				end
				default: begin
					state_reg <= SPI_IDLE;
				end
			endcase
		end
	end

	// read mux; inductance bytes come from the held copy so they pair up
	always_comb begin
		case (shift_next[6:0])
			ADDR_IND_LOW: rdata = ind_hold_reg[7:0];
			ADDR_IND_HIGH: rdata = ind_hold_reg[15:8];
			ADDR_REF_COUNT_LOW: rdata = ref_count_lo_reg;
			ADDR_REF_COUNT_HIGH: rdata = ref_count_hi_reg;
			ADDR_OFFSET_LOW: rdata = offset_lo_reg;
			ADDR_OFFSET_HIGH: rdata = offset_hi_reg;
			default: rdata = UNMAPPED_READ;
		endcase
	end

	// transmit shifter: loaded at command end, advanced after each master sample
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_reg <= 8'h00;
		end else if (byte_done && state_reg == SPI_ADDR) begin
			tx_reg <= shift_next[CMD_READ_BIT] ? rdata : 8'h00;
		end else if (sclk_rise && state_reg == SPI_DATA) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	assign spi_out.sdo = tx_reg[7];
	assign spi_out.sdo_oe = ~spi_in.cs_n;

	// ********************************
	// register writes
	// ********************************
	// result registers have no write path: writes there are dropped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_count_lo_reg <= REG_RESET;
			ref_count_hi_reg <= REG_RESET;
			offset_lo_reg <= REG_RESET;
			offset_hi_reg <= REG_RESET;
		end else if (wr_strobe) begin
			case (addr_reg)
				ADDR_REF_COUNT_LOW: ref_count_lo_reg <= shift_next;
				ADDR_REF_COUNT_HIGH: ref_count_hi_reg <= shift_next;
				ADDR_OFFSET_LOW: offset_lo_reg <= shift_next;
				ADDR_OFFSET_HIGH: offset_hi_reg <= shift_next;
				default: begin
				end
			endcase
		end
	end

	assign hires_reference_count = {ref_count_hi_reg, ref_count_lo_reg};
	assign hires_offset = {offset_hi_reg, offset_lo_reg};

	// ********************************
	// inductance result
	// ********************************
	// snapshot on the loss-result read so a later read of either byte is coherent
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ind_hold_reg <= '0;
		end else if (byte_done && state_reg == SPI_ADDR && shift_next[CMD_READ_BIT]
				&& shift_next[6:0] == ADDR_LOSS_LOW) begin
			ind_hold_reg <= ind_live_reg;
		end
	end

	// window of response_time_setting sensor edges; zero setting never closes it
	assign window_end = sensor_edge && (response_time_setting != 16'h0000)
		&& (sens_cnt_reg + 16'h0001 >= response_time_setting);

	// reference periods counted in thirds: acc = floor(cycles/3), saturating
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sens_cnt_reg <= 16'h0000;
			div3_reg <= 2'h0;
			acc_reg <= '0;
			ind_live_reg <= '0;
		end else if (window_end) begin
			sens_cnt_reg <= 16'h0000;
			div3_reg <= 2'h0;
			acc_reg <= '0;
			ind_live_reg <= acc_reg;
		end else begin
			if (sensor_edge) begin
				sens_cnt_reg <= sens_cnt_reg + 16'h0001;
			end
			if (div3_reg == 2'(IND_DIVISOR - 1)) begin
				div3_reg <= 2'h0;
				if (acc_reg != '1) begin
					acc_reg <= acc_reg + 1'b1;
				end
			end else begin
				div3_reg <= div3_reg + 2'h1;
			end
		end
	end

	// ********************************
	// high-resolution conversion
	// ********************************
	// clk stands in for the reference clock input; zero count still runs 55 periods
	assign conv_len = 21'(hires_reference_count) * 21'(HIRES_COUNT_MULT) + 21'(HIRES_COUNT_EXTRA);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_cnt_reg <= 21'h000000;
			hires_conv_done <= 1'b0;
		end else if (conv_cnt_reg + 21'h000001 >= conv_len) begin
			conv_cnt_reg <= 21'h000000;
			hires_conv_done <= 1'b1;
		end else begin
			conv_cnt_reg <= conv_cnt_reg + 21'h000001;
			hires_conv_done <= 1'b0;
		end
	end

	// offset subtracted in units of the upper 16 result bits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hires_result <= '0;
		end else if (conv_cnt_reg + 21'h000001 >= conv_len) begin
			hires_result <= hires_raw - (HIRES_W'(hires_offset) << HIRES_OFFSET_SHIFT);
		end
	end

endmodule

// ===== dv/spi_host_model.sv
// host-side serial register master for the inductance block
`timescale 1ns/1ps
module spi_host_model (
	input wire logic clk,
	output ind_conv_pkg::spi_in_s spi_in,
	input wire ind_conv_pkg::spi_out_s spi_out
);
	import ind_conv_pkg::*;
	initial spi_in = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
	// one frame, mode 0; sclk held two clocks per phase because the port samples it on clk
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, wd};
		rd = 8'h00;
		@(posedge clk) spi_in.cs_n <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk) spi_in.sclk <= 1'b0;
			spi_in.sdi <= sh[15-i];
			repeat (2) @(posedge clk);
			if (i > 7) rd = {rd[6:0], spi_out.sdo};
			spi_in.sclk <= 1'b1;
			@(posedge clk);
		end
		@(posedge clk) spi_in.sclk <= 1'b0;
		spi_in.sdi <= ~sh[0]; // released line shows the inverse
		repeat (2) @(posedge clk);
		spi_in.cs_n <= 1'b1;
		@(posedge clk);
	endtask
endmodule

// ===== dv/ind_conv_props.sv
// concurrent checks on the inductance block ports
`timescale 1ns/1ps
module ind_conv_props #(
	parameter int RESULT_W = 16,
	parameter int HIRES_W = 24
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire ind_conv_pkg::spi_in_s spi_in,
	input wire ind_conv_pkg::spi_out_s spi_out,
	input wire logic sensor_edge,
	input wire logic [15:0] response_time_setting,
	input wire logic [HIRES_W-1:0] hires_raw,
	input wire logic hires_conv_done,
	input wire logic [HIRES_W-1:0] hires_result,
	input wire logic [15:0] hires_reference_count,
	input wire logic [15:0] hires_offset
);
	import ind_conv_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [20:0] gap_reg;
	logic armed_reg;
	// cycles since last conversion end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_reg <= '0;
		end else if (hires_conv_done) begin
			gap_reg <= '0;
		end else begin
			gap_reg <= gap_reg + 21'h000001;
		end
	end
	// period only trusted when the count setting held over a whole conversion
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			armed_reg <= 1'b0;
		end else if ($changed(hires_reference_count)) begin
			armed_reg <= 1'b0;
		end else if (hires_conv_done) begin
			armed_reg <= 1'b1;
		end
	end
	sequence done_pulse_s;
		hires_conv_done ##1 !hires_conv_done;
	endsequence
	chk_oe_follows_select: assert property (spi_out.sdo_oe == !spi_in.cs_n)
		else $error("sdo enable not tied to select");
	chk_done_single: assert property (hires_conv_done |-> done_pulse_s)
		else $error("done pulse too long");
	chk_conv_period: assert property (hires_conv_done && armed_reg |->
		gap_reg == 21'({hires_reference_count, 4'h0}) + 21'(HIRES_COUNT_EXTRA - 1))
		else $error("conversion length wrong");
	chk_sdo_after_rise: assert property ($changed(spi_out.sdo) && !spi_in.cs_n && !$past(spi_in.cs_n)
		&& !$past(spi_in.cs_n, 2) |-> $past(spi_in.sclk) && !$past(spi_in.sclk, 2))
		else $error("sdo moved without sclk rise");
	chk_count_by_frame: assert property ($changed(hires_reference_count) |-> !$past(spi_in.cs_n))
		else $error("count changed outside frame");
	chk_offset_by_frame: assert property ($changed(hires_offset) |-> !$past(spi_in.cs_n))
		else $error("offset changed outside frame");
	chk_result_with_done: assert property ($changed(hires_result) |-> hires_conv_done)
		else $error("result moved without done");
	chk_offset_applied: assert property (hires_conv_done |-> hires_result ==
		$past(hires_raw) - (HIRES_W'($past(hires_offset)) << HIRES_OFFSET_SHIFT))
		else $error("offset not applied");
endmodule
bind inductance_result_hires_ctrl ind_conv_props #(.RESULT_W(RESULT_W), .HIRES_W(HIRES_W)) ind_conv_props_inst (
	.clk(clk), .sys_rst(sys_rst), .spi_in(spi_in), .spi_out(spi_out), .sensor_edge(sensor_edge),
	.response_time_setting(response_time_setting), .hires_raw(hires_raw), .hires_conv_done(hires_conv_done),
	.hires_result(hires_result), .hires_reference_count(hires_reference_count), .hires_offset(hires_offset));

// ===== dv/tb.sv
// register-level testbench for the inductance block
`timescale 1ns/1ps
module tb;
	import ind_conv_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	spi_in_s spi_in;
	spi_out_s spi_out;
	logic sensor_edge = 1'b0;
	logic [15:0] response_time_setting = 16'h000B;
	logic [23:0] hires_raw = 24'h123456;
	logic hires_conv_done;
	logic [23:0] hires_result;
	logic [15:0] hires_reference_count;
	logic [15:0] hires_offset;
	logic [7:0] rd;
	logic [6:0] amap [7] = '{ADDR_IND_LOW, ADDR_IND_HIGH, ADDR_REF_COUNT_LOW, ADDR_REF_COUNT_HIGH,
		ADDR_OFFSET_LOW, ADDR_OFFSET_HIGH, 7'h10};
	int n_errors = 0;
	int total_checks = 0;
	int gap = 0;
	int k;
	always #4 clk = ~clk;
	inductance_result_hires_ctrl inductance_result_hires_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
		.spi_in(spi_in), .spi_out(spi_out), .sensor_edge(sensor_edge),
		.response_time_setting(response_time_setting), .hires_raw(hires_raw),
		.hires_conv_done(hires_conv_done), .hires_result(hires_result),
		.hires_reference_count(hires_reference_count), .hires_offset(hires_offset));
	spi_host_model spi_host_model_inst (.clk(clk), .spi_in(spi_in), .spi_out(spi_out));
	// sensor stand-in: windows of 11 edges 11 clocks apart give 121 cycles, 40 whatever the edge alignment
	always @(posedge clk) begin
		gap <= (gap == 10) ? 0 : gap + 1;
		sensor_edge <= (gap == 10);
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rreg(input logic [6:0] a, input logic [7:0] e);
		spi_host_model_inst.frame({1'b1, a}, 8'h00, rd);
		chk({16'h0000, rd}, {16'h0000, e});
	endtask
	task automatic wreg(input logic [6:0] a, input logic [7:0] d);
		spi_host_model_inst.frame({1'b0, a}, d, rd);
	endtask
	// bounded wait for the next conversion end, k counts edges in between
	task automatic wait_done();
		k = 0;
		@(posedge clk);
		while (hires_conv_done !== 1'b1 && k < 2000) begin
			@(posedge clk);
			k++;
		end
	endtask
	task automatic finish_test();
		if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rreg(amap[i], 8'h00);
		wreg(ADDR_REF_COUNT_LOW, 8'h02);
		wreg(ADDR_REF_COUNT_HIGH, 8'h00);
		wreg(ADDR_OFFSET_LOW, 8'h34);
		wreg(ADDR_OFFSET_HIGH, 8'h12);
		wreg(ADDR_IND_HIGH, 8'hFF);
		rreg(ADDR_IND_HIGH, 8'h00);
		rreg(ADDR_REF_COUNT_LOW, 8'h02);
		rreg(ADDR_OFFSET_HIGH, 8'h12);
		chk({8'h00, hires_reference_count}, 24'h000002);
		chk({8'h00, hires_offset}, 24'h001234);
		wait_done();
		wait_done();
		chk(24'(k + 1), 24'(2 * HIRES_COUNT_MULT + HIRES_COUNT_EXTRA));
		chk(hires_result, 24'h000056);
		spi_host_model_inst.frame({1'b1, ADDR_LOSS_LOW}, 8'h00, rd);
		rreg(ADDR_IND_LOW, 8'h28);
		rreg(ADDR_IND_HIGH, 8'h00);
		finish_test();
	end
endmodule
